//--- btu_pkg.sv
// Shared constants and types for the block transfer unit
package btu_pkg;

    // ------------------------------------------------------------
    // Word layout (LSB-indexed; printed bit 15 is our bit 0)
    // ------------------------------------------------------------
    localparam int             WORD_W      = 16;
    localparam int             CHAN_W      = 3;
    localparam int             NUM_CHAN    = 8;
    localparam int             CHAN_LSB    = 0;
    localparam int             DEV_FLD_LSB = 3;
    localparam int             DEV_FLD_W   = 5;
    localparam int             CNT_LOW_W   = 8;
    localparam int             LIST_LEN    = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0]    WORD_RST    = 16'h0000;
    localparam logic [2:0]     CHAN_RST    = 3'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int             CLK_HZ          = 25_000_000;
    localparam int             MAX_RATE_HZ     = 500_000;
    // Least spacing between two transfers, rounded up
    localparam int             XFER_GAP_CYC    = (CLK_HZ + MAX_RATE_HZ - 1) / MAX_RATE_HZ;
    localparam int             GAP_W           = 6;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        BTU_OP_LIST,
        BTU_OP_READ,
        BTU_OP_WRITE
    } btu_op_t;

    typedef struct packed
    {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        we;
    } btu_mem_cmd_t;

endpackage : btu_pkg

//--- btu_block_transfer_unit.sv
// Block transfer unit: activate decode, list fetch, data counting, memory requests
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
//
// Overview of operation
// - Data transfers are spaced so the rate never exceeds 500 kHz.
// - Never claim two consecutive available memory cycles.
// - Device field of word one and all of list word three pass uninterpreted.
// - Accept both activate words when idle, only word one when device busy.
// - Matching activate pulses first-word strobe one clock; device field stays visible.
// - Busy stores nothing; otherwise word one to slot one, word two to slot three.
// - Channel field of word one is compared with the selected 3-bit code.
// - Word two is shown to the device during the second-word strobe, one clock longer if a list fetch starts then.
// - List fetch starts on device command, using the address in slot three, or in slot four when list_use_four is set.
// - Fetch exactly four consecutive list words from slot three or four address.
// - List word one goes to slot two and the bus with first-list strobe.
// - List word two goes to slot one and loads all sixteen counter bits, second-list strobe.
// - Counter zero is reported for the low eight bits and all sixteen.
// - List word three shown at third strobe, then held as register file output.
// - List word four goes to the slot not used for this fetch.
// - Channel code picks answered activates and request/acknowledge lines.
// - All eight lines arrive; only the selected one is driven or watched.
// - Raise a request before each transfer and wait any time for the grant.
module btu_block_transfer_unit
    import btu_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    input  wire logic [CHAN_W-1:0]     chan_switch,
    input  wire logic                  act_word1_valid,
    input  wire logic                  act_word2_valid,
    input  wire logic [WORD_W-1:0]     act_data,
    output logic      [NUM_CHAN-1:0]   mem_req,
    input  wire logic [NUM_CHAN-1:0]   mem_grant,
    output btu_mem_cmd_t               mem_cmd,
    input  wire logic [WORD_W-1:0]     mem_rdata,
    input  wire logic                  dev_busy,
    input  wire logic                  list_start,
    input  wire logic                  list_use_four,
    input  wire logic                  xfer_req,
    input  wire logic                  xfer_write,
    input  wire logic [WORD_W-1:0]     xfer_wdata,
    output logic                       first_word_strobe,
    output logic                       second_word_strobe,
    output logic      [DEV_FLD_W-1:0]  dev_field,
    output logic                       list1_strobe,
    output logic                       list2_strobe,
    output logic                       list3_strobe,
    output logic                       list_done,
    output logic                       xfer_done,
    output logic      [WORD_W-1:0]     dev_data,
    output logic                       cnt_zero_low,
    output logic                       cnt_zero_full
);

    // ------------------------------------------------------------
    // Channel switch synchroniser
    // ------------------------------------------------------------
    logic [CHAN_W-1:0] chan_meta;
    logic [CHAN_W-1:0] chan_code;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            chan_meta <= CHAN_RST;
            chan_code <= CHAN_RST;
        end
        else
        begin
            chan_meta <= chan_switch;
            chan_code <= chan_meta;
        end
    end

    // ------------------------------------------------------------
    // Activate decode
    // ------------------------------------------------------------
    logic chan_match;
    logic word2_armed;
    logic take_word1;
    logic take_word2;

    assign chan_match = act_data[CHAN_LSB +: CHAN_W] == chan_code;
    assign take_word1 = act_word1_valid && chan_match;
    assign take_word2 = act_word2_valid && word2_armed;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            word2_armed       <= 1'b0;
            first_word_strobe <= 1'b0;
            second_word_strobe <= 1'b0;
            dev_field         <= '0;
        end
        else
        begin
            first_word_strobe  <= take_word1;
            second_word_strobe <= take_word2;
            // Any word one decides the next word two, so a foreign one disarms
            if (act_word1_valid)
                word2_armed <= chan_match && !dev_busy;
            else if (act_word2_valid)
                word2_armed <= 1'b0;
            // Field is held for the device; never decoded here
            if (take_word1)
                dev_field <= act_data[DEV_FLD_LSB +: DEV_FLD_W];
        end
    end

    // ------------------------------------------------------------
    // Memory request engine
    // ------------------------------------------------------------
    typedef enum
    {
        ST_IDLE,
        ST_LIST,
        ST_DATA
    } btu_state_t;

    btu_state_t       state;
    logic             req_pending;
    logic [GAP_W-1:0] gap_cnt;
    logic [1:0]       list_idx;
    logic             used_four;
    logic             xfer_pend;
    logic             xfer_is_wr;
    logic [15:0]      xfer_wd;
    logic             granted;
    logic             gap_open;
    logic             list_go;
    logic [15:0]      word3;
    logic [15:0]      data_cnt;
    logic [15:0]      next_cnt;
    logic [15:0]      rf [1:4];

    assign granted  = req_pending && mem_grant[chan_code];
    assign gap_open = gap_cnt == '0;
    assign list_go  = state == ST_IDLE && list_start;

    // Per-channel request lines, only the selected one ever rises
    for (genvar gi = 0; gi < NUM_CHAN; gi++)
    begin : g_req
        always_ff @(posedge mclk or negedge resetn)
        begin
            if (!resetn)
                mem_req[gi] <= 1'b0;
            else
                mem_req[gi] <= req_pending && !granted && chan_code == CHAN_W'(gi);
        end
    end

    // Gap counter keeps a fixed spacing after every grant
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            gap_cnt <= '0;
        else if (granted)
            gap_cnt <= GAP_W'(XFER_GAP_CYC - 1);
        else if (!gap_open)
            gap_cnt <= gap_cnt - GAP_W'(1);
    end

    // Device transfer requests wait here until their data transfer is granted
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            xfer_pend  <= 1'b0;
            xfer_is_wr <= 1'b0;
            xfer_wd    <= WORD_RST;
        end
        else if (xfer_req && !xfer_pend)
        begin
            xfer_pend  <= 1'b1;
            xfer_is_wr <= xfer_write;
            xfer_wd    <= xfer_wdata;
        end
        else if (state == ST_DATA && granted)
        begin
            xfer_pend <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            state       <= ST_IDLE;
            req_pending <= 1'b0;
            list_idx    <= 2'h0;
            used_four   <= 1'b0;
            mem_cmd     <= '0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (list_start)
                    begin
                        state     <= ST_LIST;
                        list_idx  <= 2'h0;
                        used_four <= list_use_four;
                    end
                    else if (xfer_pend)
                    begin
                        state <= ST_DATA;
                    end
                end
                ST_LIST:
                begin
                    if (!req_pending && gap_open)
                    begin
                        req_pending   <= 1'b1;
                        mem_cmd.we    <= 1'b0;
                        mem_cmd.wdata <= WORD_RST;
                        mem_cmd.addr  <= (used_four ? rf[4] : rf[3]) + 16'(list_idx);
                    end
                    else if (granted)
                    begin
                        req_pending <= 1'b0;
                        list_idx    <= list_idx + 2'h1;
                        if (list_idx == 2'(LIST_LEN - 1))
                            state <= ST_IDLE;
                    end
                end
                ST_DATA:
                begin
                    if (!req_pending && gap_open)
                    begin
                        req_pending   <= 1'b1;
                        mem_cmd.we    <= xfer_is_wr;
                        mem_cmd.wdata <= xfer_wd;
                        mem_cmd.addr  <= rf[2];
                    end
                    else if (granted)
                    begin
                        req_pending <= 1'b0;
                        state       <= ST_IDLE;
                    end
                end
                default:
                begin
                    state       <= ST_IDLE;
                    req_pending <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic list_grant;
    logic data_grant;

    assign list_grant = state == ST_LIST && granted;
    assign data_grant = state == ST_DATA && granted;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 1; i <= 4; i++)
                rf[i] <= WORD_RST;
            word3 <= WORD_RST;
        end
        else if (take_word1 && !dev_busy)
        begin
            rf[1] <= act_data;
        end
        else if (take_word2)
        begin
            rf[3] <= act_data;
        end
        else if (list_grant)
        begin
            case (list_idx)
                2'h0: rf[2] <= mem_rdata;
                2'h1: rf[1] <= mem_rdata;
                2'h2: word3 <= mem_rdata;
                default:
                begin
                    // Chaining address lands in the slot not used now
                    if (used_four)
                        rf[3] <= mem_rdata;
                    else
                        rf[4] <= mem_rdata;
                end
            endcase
        end
        else if (data_grant)
        begin
            rf[2] <= rf[2] + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Data counter
    // ------------------------------------------------------------
    always_comb
    begin
        next_cnt = data_cnt;
        if (list_grant && list_idx == 2'h1)
            next_cnt = mem_rdata;
        else if (data_grant && data_cnt != WORD_RST)
            next_cnt = data_cnt - 16'h0001;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            data_cnt      <= WORD_RST;
            cnt_zero_low  <= 1'b1;
            cnt_zero_full <= 1'b1;
        end
        else
        begin
            data_cnt      <= next_cnt;
            // Upper byte may carry device bits, so low byte is reported alone
            cnt_zero_low  <= next_cnt[CNT_LOW_W-1:0] == '0;
            cnt_zero_full <= next_cnt == WORD_RST;
        end
    end

    // ------------------------------------------------------------
    // Device strobes and data bus
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            list1_strobe <= 1'b0;
            list2_strobe <= 1'b0;
            list3_strobe <= 1'b0;
            list_done    <= 1'b0;
            xfer_done    <= 1'b0;
        end
        else
        begin
            list1_strobe <= list_grant && list_idx == 2'h0;
            list2_strobe <= list_grant && list_idx == 2'h1;
            list3_strobe <= list_grant && list_idx == 2'h2;
            list_done    <= list_grant && list_idx == 2'h3;
            xfer_done    <= data_grant;
        end
    end

    // Word two is on the bus in its strobe cycle (one more if a list fetch starts then); otherwise
    // list words one to three and read data follow their grants, else list word three is shown
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            dev_data <= WORD_RST;
        else if (take_word2)
            dev_data <= act_data;
        else if (list_grant && list_idx != 2'h3)
            dev_data <= mem_rdata;
        else if (data_grant && !xfer_is_wr)
            dev_data <= mem_rdata;
        else if (!list_go)
            dev_data <= word3;
    end

endmodule : btu_block_transfer_unit

//--- btu_props.sv
// Checker of port-level timing for the block transfer unit
`timescale 1ns/10ps
module btu_props
    import btu_pkg::*;
(
    input wire logic                 mclk,
    input wire logic                 resetn,
    input wire logic [CHAN_W-1:0]    chan_switch,
    input wire logic                 act_word1_valid,
    input wire logic                 act_word2_valid,
    input wire logic [WORD_W-1:0]    act_data,
    input wire logic                 dev_busy,
    input wire logic [NUM_CHAN-1:0]  mem_req,
    input wire logic [NUM_CHAN-1:0]  mem_grant,
    input wire logic                 first_word_strobe,
    input wire logic                 second_word_strobe,
    input wire logic [DEV_FLD_W-1:0] dev_field,
    input wire logic [WORD_W-1:0]    dev_data,
    input wire logic                 list1_strobe,
    input wire logic                 list3_strobe,
    input wire logic                 xfer_done
);
    // --------------------
    // Helpers
    // --------------------
    logic       armed;
    logic [5:0] gcnt;
    wire  logic hit  = act_word1_valid && act_data[2:0] == chan_switch;
    wire  logic take = |(mem_grant & mem_req);

    // Word two counts only after a matching word one while idle
    always_ff @(posedge mclk or negedge resetn)
        if (!resetn)
            armed <= 1'b0;
        else if (act_word1_valid)
            armed <= hit && !dev_busy;
        else if (act_word2_valid)
            armed <= 1'b0;

    // Saturates so the first request after reset is not flagged
    always_ff @(posedge mclk or negedge resetn)
        if (!resetn)
            gcnt <= 6'h3F;
        else if (take)
            gcnt <= 6'h00;
        else if (gcnt != 6'h3F)
            gcnt <= gcnt + 6'h01;

    // --------------------
    // Properties
    // --------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    property p_req_sel; mem_req == 8'h00 || mem_req == (8'h01 << chan_switch); endproperty
    property p_req_hold; mem_req != 8'h00 && !take |=> $stable(mem_req); endproperty
    property p_req_drop; take |=> mem_req == 8'h00; endproperty
    property p_gap; $rose(|mem_req) |-> gcnt >= 6'h31; endproperty
    property p_fws; hit |=> first_word_strobe && dev_field == $past(act_data[7:3]); endproperty
    property p_sws;
        act_word2_valid && armed |=> second_word_strobe && dev_data == $past(act_data);
    endproperty
    property p_sws_only; second_word_strobe |-> $past(act_word2_valid && armed); endproperty
    property p_list; list1_strobe |-> ##[100:200] list3_strobe; endproperty
    property p_xfer; xfer_done |-> $past(take); endproperty

    a_req_sel: assert property (p_req_sel) else $error("request on wrong line");
    a_req_hold: assert property (p_req_hold) else $error("request dropped");
    a_req_drop: assert property (p_req_drop) else $error("request kept");
    a_gap: assert property (p_gap) else $error("requests too close");
    a_fws: assert property (p_fws) else $error("first strobe wrong");
    a_sws: assert property (p_sws) else $error("second strobe missing");
    a_sws_only: assert property (p_sws_only) else $error("stray second strobe");
    a_list: assert property (p_list) else $error("list too slow");
    a_xfer: assert property (p_xfer) else $error("done without grant");

    c_second: cover property (second_word_strobe);
    c_list: cover property (list3_strobe);
    c_xfer: cover property (xfer_done);
endmodule : btu_props

bind btu_block_transfer_unit btu_props btu_props_i (
    .mclk, .resetn, .chan_switch, .act_word1_valid, .act_word2_valid, .act_data, .dev_busy,
    .mem_req, .mem_grant, .first_word_strobe, .second_word_strobe, .dev_field, .dev_data,
    .list1_strobe, .list3_strobe, .xfer_done);

//--- btu_mem_model.sv
// Model of the memory port expander facing the unit
`timescale 1ns/10ps
module btu_mem_model
    import btu_pkg::*;
(
    input  wire logic [CHAN_W-1:0]   chan,
    input  wire logic                mclk,
    input  wire logic                resetn,
    input  wire logic [NUM_CHAN-1:0] mem_req,
    input  wire btu_mem_cmd_t        mem_cmd,
    output logic      [NUM_CHAN-1:0] mem_grant,
    output logic      [WORD_W-1:0]   mem_rdata,
    output btu_mem_cmd_t             last_cmd
);
    // --------------------
    // Grant logic
    // --------------------
    logic       gnt;
    logic       slow;
    logic [2:0] wait_cnt;

    assign mem_grant = gnt ? (8'h01 << chan) : 8'h00;

    // Prompt and slow answers alternate; idle bus shows inverted data
    always_ff @(posedge mclk or negedge resetn)
        if (!resetn)
        begin
            gnt       <= 1'b0;
            slow      <= 1'b0;
            wait_cnt  <= 3'h0;
            mem_rdata <= 16'h0000;
            last_cmd  <= '0;
        end
        else if (gnt)
        begin
            gnt       <= 1'b0;
            slow      <= !slow;
            wait_cnt  <= 3'h0;
            mem_rdata <= ~mem_rdata;
        end
        else if (mem_req[chan] && wait_cnt >= (slow ? 3'h4 : 3'h0))
        begin
            gnt       <= 1'b1;
            mem_rdata <= mem_cmd.addr + 16'h1111;
            last_cmd  <= mem_cmd;
        end
        else if (mem_req[chan])
            wait_cnt <= wait_cnt + 3'h1;
endmodule : btu_mem_model

//--- tb.sv
// Testbench: activate decode, list fetch, chaining and data transfers
`timescale 1ns/10ps
module tb
    import btu_pkg::*;
;
    localparam logic [2:0] CH = 3'h3;

    logic                 mclk            = 1'b0;
    logic                 resetn          = 1'b0;
    logic [CHAN_W-1:0]    chan_switch     = CH;
    logic                 act_word1_valid = 1'b0;
    logic                 act_word2_valid = 1'b0;
    logic [WORD_W-1:0]    act_data        = 16'h0000;
    logic                 dev_busy        = 1'b0;
    logic                 list_start      = 1'b0;
    logic                 list_use_four   = 1'b0;
    logic                 xfer_req        = 1'b0;
    logic                 xfer_write      = 1'b0;
    logic [WORD_W-1:0]    xfer_wdata      = 16'h0000;
    logic [NUM_CHAN-1:0]  mem_req;
    logic [NUM_CHAN-1:0]  mem_grant;
    logic [WORD_W-1:0]    mem_rdata;
    logic [WORD_W-1:0]    dev_data;
    logic [DEV_FLD_W-1:0] dev_field;
    wire  logic [4:0]     evt;
    logic                 first_word_strobe;
    logic                 second_word_strobe;
    logic                 cnt_zero_low;
    logic                 cnt_zero_full;
    btu_mem_cmd_t         mem_cmd;
    btu_mem_cmd_t         last_cmd;
    int                   err_total;
    int                   total_checks;

    always #20 mclk = ~mclk;

    btu_block_transfer_unit btu_block_transfer_unit_i (
        .mclk, .resetn, .chan_switch, .act_word1_valid, .act_word2_valid, .act_data,
        .mem_req, .mem_grant, .mem_cmd, .mem_rdata, .dev_busy, .list_start, .list_use_four,
        .xfer_req, .xfer_write, .xfer_wdata, .first_word_strobe, .second_word_strobe,
        .dev_field, .list1_strobe(evt[0]), .list2_strobe(evt[1]), .list3_strobe(evt[2]),
        .list_done(evt[3]), .xfer_done(evt[4]), .dev_data, .cnt_zero_low, .cnt_zero_full);

    btu_mem_model btu_mem_model_i (
        .chan(chan_switch), .mclk, .resetn, .mem_req, .mem_cmd, .mem_grant, .mem_rdata,
        .last_cmd);

    // --------------------
    // Tasks
    // --------------------
    task print_verdict;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            $display("BAD %0t got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask : chk

    // Strobes are single-cycle, so every cycle is looked at
    task automatic wait_hi(input int b);
        for (int n = 0; n < 400; n++)
        begin
            @(posedge mclk);
            #1;
            if (evt[b] === 1'b1)
                return;
        end
        $display("BAD %0t wait ran out", $time);
        err_total++;
        print_verdict();
    endtask : wait_hi

    task act(input logic [15:0] w1, input logic [15:0] w2, input logic busy);
        @(posedge mclk);
        act_word1_valid <= 1'b1;
        act_data        <= w1;
        dev_busy        <= busy;
        @(posedge mclk);
        act_word1_valid <= 1'b0;
        act_word2_valid <= 1'b1;
        act_data        <= w2;
        #1;
        chk(16'(first_word_strobe), 16'(w1[2:0] == CH));
        @(posedge mclk);
        act_word2_valid <= 1'b0;
        #1;
        chk(16'(second_word_strobe), 16'(w1[2:0] == CH && !busy));
    endtask : act

    task run_list(input logic four);
        @(posedge mclk);
        list_start    <= 1'b1;
        list_use_four <= four;
        @(posedge mclk);
        list_start    <= 1'b0;
        wait_hi(0);
    endtask : run_list

    task xfer(input logic wr, input logic [15:0] d);
        @(posedge mclk);
        xfer_req   <= 1'b1;
        xfer_write <= wr;
        xfer_wdata <= d;
        @(posedge mclk);
        xfer_req   <= 1'b0;
        wait_hi(4);
    endtask : xfer

    // --------------------
    // Sequence
    // --------------------
    initial
    begin
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        #1;
        chk(16'({cnt_zero_full, cnt_zero_low}), 16'h0003);
        repeat (3) @(posedge mclk);
        act({8'hC3, 5'h1A, CH}, 16'h00EE, 1'b0);
        chk(dev_data, 16'h00EE);
        chk(16'(dev_field), 16'h001A);
        @(posedge mclk);
        #1;
        chk(dev_data, 16'h0000);
        // A foreign word one between ours and word two takes the arming away
        @(posedge mclk);
        act_word1_valid <= 1'b1;
        act_data        <= {8'h00, 5'h00, CH};
        @(posedge mclk);
        act_data        <= {8'h00, 5'h00, CH + 3'h1};
        @(posedge mclk);
        act_word1_valid <= 1'b0;
        act_word2_valid <= 1'b1;
        act_data        <= 16'h5555;
        @(posedge mclk);
        act_word2_valid <= 1'b0;
        #1;
        chk(16'(second_word_strobe), 16'h0000);
        // Busy word two must not replace the stored list address
        for (int c = 0; c < 8; c++)
            act({8'h00, 5'h00, 3'(c)}, 16'h7777, 1'b1);
        run_list(1'b0);
        chk(dev_data, 16'h11FF);
        wait_hi(1);
        chk(dev_data, 16'h1200);
        wait_hi(2);
        chk(dev_data, 16'h1201);
        chk(16'({cnt_zero_full, cnt_zero_low}), 16'h0001);
        wait_hi(3);
        chk(dev_data, 16'h1201);
        chk(last_cmd.addr, 16'h00F1);
        xfer(1'b0, 16'h0000);
        chk(dev_data, 16'h2310);
        chk(last_cmd.addr, 16'h11FF);
        xfer(1'b1, 16'hBEEF);
        chk(last_cmd.wdata, 16'hBEEF);
        chk(last_cmd.addr, 16'h1200);
        chk(16'(last_cmd.we), 16'h0001);
        chk(16'(cnt_zero_low), 16'h0000);
        run_list(1'b1);
        chk(dev_data, 16'h2313);
        wait_hi(3);
        chk(last_cmd.addr, 16'h1205);
        // Chain address from a slot-four fetch must have landed in slot three
        run_list(1'b0);
        chk(dev_data, 16'h3427);
        print_verdict();
    end
endmodule : tb
